// >>> inc/svc_pkg.sv
// Constants, types and register map of the service-cycle device controller
// Contract
// - Order input drives status and last-data with strobe
// - Order input after count done, stop, or fault
// - Either side ends data; only processor ends service
// - Both flags low: strobe at least once more
// - Last-data alone: one more strobe for order
// - Service-end flag high completes the service cycle
// - Hold select lines steady whole service cycle
// - Controller picks direction; cycle reads or writes
// - No order input before an order output taken
// - Exactly one order input per order output
// - Data cycles carry one or more bytes
// - Status bit 0 fault, bit 1 wrong length
// - Drop strobe on acknowledge; await its release
// - Count done order forces channel-finish order input; code starts it only while an order input is owed
// - Status bit 3 reports channel finish; code sets it in every order input
// - Status bit 4 reports abnormal finish
package svc_pkg;
	// Cycle kinds: bit 1 is order select, bit 0 is output direction
	localparam logic [1:0] KIND_DIN  = 2'h0;
	localparam logic [1:0] KIND_DOUT = 2'h1;
	localparam logic [1:0] KIND_OIN  = 2'h2;
	localparam logic [1:0] KIND_ORDER_OUTPUT_CYCLE = 2'h3;
	// Register byte offsets
	localparam logic [3:0] OFS_CTRL = 4'h0;
	localparam logic [3:0] OFS_TX   = 4'h4;
	localparam logic [3:0] OFS_FLT  = 4'h8;
	localparam logic [3:0] OFS_STAT = 4'hC;
	// Control register fields
	localparam int CTRL_GO  = 5;
	localparam int CNT_LSB  = 2;
	// Fault register fields
	localparam int FLT_TE  = 0;
	localparam int FLT_WL  = 1;
	localparam int FLT_ABN = 2;
	// Status byte bits of an order input
	localparam int SB_TE  = 0;
	localparam int SB_WL  = 1;
	localparam int SB_CHF = 3;
	localparam int SB_ABN = 4;
	// Terminal order bits
	localparam int TO_CNT_DONE = 1;
	// Order output value meaning stop
	localparam logic [7:0] ORDER_STOP = 8'h00;
	// Pins driven toward the processor
	typedef struct packed {
		logic       strobe;
		logic       order_sel;
		logic       dir_sel;
		logic       last_data;
		logic       last_data_oe;
		logic [7:0] data;
		logic       data_oe;
	} pin_out_t;
	// Pins sensed from the processor
	typedef struct packed {
		logic       ack;
		logic       service_end;
		logic       last_data;
		logic [7:0] data;
	} pin_in_t;
endpackage

// >>> src/svc_ctrl.sv
// Device controller side of the byte-wide service cycle
//
// The Avalon-MM register port and the address map were left to the implementer.
module svc_ctrl (
	input  wire logic             clock_in,
	input  wire logic             resetn_in,
	input  wire logic [3:0]       avs_address_in,
	input  wire logic             avs_read_in,
	input  wire logic             avs_write_in,
	input  wire logic [31:0]      avs_writedata_in,
	output logic      [31:0]      avs_readdata_out,
	output logic                  avs_waitrequest_out,
	input  wire svc_pkg::pin_in_t pins_in,
	output svc_pkg::pin_out_t     pins_out
);
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_WACK = 2'b01,
		ST_WREL = 2'b10
	} state_t;

	state_t            state_q;     // Handshake phase
	svc_pkg::pin_in_t  sync1_q;     // First synchroniser stage
	svc_pkg::pin_in_t  sync2_q;     // Safe pin copy
	logic              wait_q;      // Bus wait state
	logic [31:0]       rdata_q;     // Bus read data
	logic [1:0]        kind_q;      // Cycle kind
	logic [2:0]        cnt_max_q;   // Bytes minus one
	logic [2:0]        cnt_q;       // Bytes exchanged
	logic [7:0]        tx_q;        // Byte to send
	logic [2:0]        flt_q;       // Fault bits for order input
	logic [7:0]        rx_q;        // Last byte received
	logic [7:0]        term_q;      // Last terminal order
	logic              to_q;        // Terminal order subcycle
	logic              es_l_q;      // Service end seen at ack
	logic              ld_l_q;      // Last data seen at ack
	logic              order_output_cycle_q;      // Order output taken, input owed
	logic              auto_q;      // Channel finish input pending
	logic              abn_q;       // Current input reports fault
	logic              rs_q;        // Request strobe
	logic              dor_q;       // Order select
	logic              ior_q;       // Direction select
	logic              ld_q;        // Own last-data drive
	logic [7:0]        dout_q;      // Data drive
	logic              doe_q;       // Data drive enable
	logic              bus_wr;      // Write taking effect
	logic              sw_go;       // Software start
	logic              start;       // Cycle start this edge
	logic [1:0]        start_kind;  // Kind being started
	logic              ack_s;       // Synced acknowledge
	logic              done;        // Cycle completes this edge

	// Controller sends on data in and order input, except terminal order
	function automatic logic sends(input logic [1:0] k);
		sends = (k == svc_pkg::KIND_DIN) || (k == svc_pkg::KIND_OIN);
	endfunction

	// Status byte: channel finish always set, fault bits from software
	function automatic logic [7:0] status_byte(input logic [2:0] f, input logic a);
		status_byte = 8'h00;
		status_byte[svc_pkg::SB_TE]  = f[svc_pkg::FLT_TE];
		status_byte[svc_pkg::SB_WL]  = f[svc_pkg::FLT_WL];
		status_byte[svc_pkg::SB_CHF] = 1'b1;
		status_byte[svc_pkg::SB_ABN] = a;
	endfunction

	assign ack_s  = sync2_q.ack;
	assign bus_wr = avs_write_in && !wait_q;
	assign sw_go  = bus_wr && (avs_address_in == svc_pkg::OFS_CTRL)
		&& avs_writedata_in[svc_pkg::CTRL_GO];
	// Order input needs a prior order output; refused otherwise
	always_comb begin
		start_kind = avs_writedata_in[1:0];
		start      = 1'b0;
		if (state_q == ST_IDLE) begin
			if (auto_q && order_output_cycle_q) begin
				start_kind = svc_pkg::KIND_OIN;
				start      = 1'b1;
			end else if (sw_go) begin
				start = (start_kind != svc_pkg::KIND_OIN) || order_output_cycle_q;
			end
		end
	end
	assign done = (state_q == ST_WREL) && !ack_s && es_l_q;

	// Two-stage synchroniser for every sensed pin
	always_ff @(posedge clock_in) begin
		if (!resetn_in) begin
			sync1_q <= '0;
			sync2_q <= '0;
		end else begin
			sync1_q <= pins_in;
			sync2_q <= sync1_q;
		end
	end

	// Avalon slave: one wait cycle, then answer
	always_ff @(posedge clock_in) begin
		if (!resetn_in) begin
			wait_q  <= 1'b1;
			rdata_q <= '0;
		end else begin
			wait_q <= !((avs_read_in || avs_write_in) && wait_q);
			case (avs_address_in)
				svc_pkg::OFS_CTRL: rdata_q <= {27'h0, cnt_max_q, kind_q};
				svc_pkg::OFS_TX:   rdata_q <= {24'h0, tx_q};
				svc_pkg::OFS_FLT:  rdata_q <= {29'h0, flt_q};
				svc_pkg::OFS_STAT: begin
					rdata_q <= {8'h0, term_q, rx_q, 4'h0, auto_q, order_output_cycle_q,
						to_q, state_q != ST_IDLE};
				end
				default: rdata_q <= '0;
			endcase
		end
	end

	// Software byte and fault registers
	always_ff @(posedge clock_in) begin
		if (!resetn_in) begin
			tx_q  <= '0;
			flt_q <= '0;
		end else if (bus_wr && avs_address_in == svc_pkg::OFS_TX) begin
			tx_q <= avs_writedata_in[7:0];
		end else if (bus_wr && avs_address_in == svc_pkg::OFS_FLT) begin
			flt_q <= avs_writedata_in[2:0];
		end
	end

	// Cycle kind and byte limit, fixed for the whole service cycle
	always_ff @(posedge clock_in) begin
		if (!resetn_in) begin
			kind_q    <= svc_pkg::KIND_DIN;
			cnt_max_q <= '0;
			abn_q     <= 1'b0;
		end else if (start) begin
			kind_q    <= start_kind;
			abn_q     <= flt_q[svc_pkg::FLT_ABN];
			// Order input is a single status byte
			cnt_max_q <= (start_kind == svc_pkg::KIND_OIN) ? 3'h0
				: avs_writedata_in[svc_pkg::CNT_LSB +: 3];
		end
	end

	// Handshake sequencer
	always_ff @(posedge clock_in) begin
		if (!resetn_in) begin
			state_q <= ST_IDLE;
			rs_q    <= 1'b0;
			to_q    <= 1'b0;
			cnt_q   <= '0;
			es_l_q  <= 1'b0;
			ld_l_q  <= 1'b0;
		end else begin
			case (state_q)
				ST_IDLE: begin
					if (start) begin
						rs_q    <= 1'b1;
						to_q    <= 1'b0;
						cnt_q   <= '0;
						state_q <= ST_WACK;
					end
				end
				ST_WACK: begin
					if (ack_s) begin
						rs_q    <= 1'b0;
						es_l_q  <= sync2_q.service_end;
						ld_l_q  <= sync2_q.last_data || ld_q;
						state_q <= ST_WREL;
					end
				end
				ST_WREL: begin
					// Next strobe only once acknowledge is released
					if (!ack_s) begin
						if (es_l_q) begin
							state_q <= ST_IDLE;
						end else if (ld_l_q) begin
							to_q    <= 1'b1;
							rs_q    <= 1'b1;
							state_q <= ST_WACK;
						end else begin
							cnt_q   <= cnt_q + 3'h1;
							rs_q    <= 1'b1;
							state_q <= ST_WACK;
						end
					end
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	// Select lines held for the whole service cycle
	always_ff @(posedge clock_in) begin
		if (!resetn_in) begin
			dor_q <= 1'b0;
			ior_q <= 1'b0;
		end else if (start) begin
			dor_q <= start_kind[1];
			ior_q <= start_kind[0];
		end
	end

	// Data and last-data drive while the controller sends
	always_ff @(posedge clock_in) begin
		if (!resetn_in) begin
			dout_q <= '0;
			doe_q  <= 1'b0;
			ld_q   <= 1'b0;
		end else if (start) begin
			doe_q  <= sends(start_kind);
			ld_q   <= sends(start_kind) && (start_kind == svc_pkg::KIND_OIN
				|| avs_writedata_in[svc_pkg::CNT_LSB +: 3] == 3'h0);
			dout_q <= (start_kind == svc_pkg::KIND_OIN)
				? status_byte(flt_q, flt_q[svc_pkg::FLT_ABN])
				: tx_q;
		end else if (state_q == ST_WREL && !ack_s) begin
			// New subcycle: terminal order is received, never sent
			doe_q  <= sends(kind_q) && !ld_l_q && !es_l_q;
			ld_q   <= sends(kind_q) && !ld_l_q && !es_l_q
				&& (cnt_q + 3'h1 == cnt_max_q);
			dout_q <= tx_q;
		end
	end

	// Received bytes: data, orders and terminal orders
	always_ff @(posedge clock_in) begin
		if (!resetn_in) begin
			rx_q   <= '0;
			term_q <= '0;
		end else if (state_q == ST_WACK && ack_s) begin
			if (to_q) begin
				term_q <= sync2_q.data;
			end else if (!sends(kind_q)) begin
				rx_q <= sync2_q.data;
			end
		end
	end

	// Order input bookkeeping: owed after order output, pending after finish
	always_ff @(posedge clock_in) begin
		if (!resetn_in) begin
			order_output_cycle_q <= 1'b0;
			auto_q <= 1'b0;
		end else if (done) begin
			if (kind_q == svc_pkg::KIND_ORDER_OUTPUT_CYCLE) begin
				order_output_cycle_q <= 1'b1;
				auto_q <= (rx_q == svc_pkg::ORDER_STOP);
			end else if (kind_q == svc_pkg::KIND_OIN) begin
				order_output_cycle_q <= 1'b0;
				auto_q <= 1'b0;
			end
			if (to_q && kind_q != svc_pkg::KIND_OIN
				&& term_q[svc_pkg::TO_CNT_DONE]) begin
				auto_q <= 1'b1;
			end
		end
	end

	assign avs_readdata_out    = rdata_q;
	assign avs_waitrequest_out = wait_q;
	assign pins_out = '{strobe: rs_q, order_sel: dor_q, dir_sel: ior_q,
		last_data: ld_q, last_data_oe: ld_q, data: dout_q, data_oe: doe_q};

	// Assertions
	sequence subcycle_end_s;
		state_q == ST_WREL && !ack_s;
	endsequence
	sequence strobe_rise_s;
		$rose(rs_q);
	endsequence

	oin_status_a: assert property (@(posedge clock_in) disable iff (!resetn_in)
		strobe_rise_s and (kind_q == svc_pkg::KIND_OIN) and !to_q |-> doe_q && ld_q)
		else $error("order input strobe without status and last-data");
	oin_gate_a: assert property (@(posedge clock_in) disable iff (!resetn_in)
		start && start_kind == svc_pkg::KIND_OIN |-> order_output_cycle_q)
		else $error("order input started without order output");
	strobe_drop_a: assert property (@(posedge clock_in) disable iff (!resetn_in)
		state_q == ST_WACK && ack_s |=> !rs_q)
		else $error("strobe not dropped on acknowledge");
	// Strobe stays low for as long as the acknowledge is still seen high
	strobe_hold_a: assert property (@(posedge clock_in) disable iff (!resetn_in)
		ack_s && !rs_q |=> !rs_q)
		else $error("strobe raised before acknowledge released");
	more_data_a: assert property (@(posedge clock_in) disable iff (!resetn_in)
		subcycle_end_s and !es_l_q and !ld_l_q |=> rs_q && !to_q)
		else $error("no further strobe with both flags low");
	order_follow_a: assert property (@(posedge clock_in) disable iff (!resetn_in)
		subcycle_end_s and !es_l_q and ld_l_q |=> rs_q && to_q)
		else $error("no terminal order strobe after last data");
	service_end_a: assert property (@(posedge clock_in) disable iff (!resetn_in)
		subcycle_end_s and es_l_q |=> state_q == ST_IDLE && !rs_q)
		else $error("service did not end on service-end flag");
	select_hold_a: assert property (@(posedge clock_in) disable iff (!resetn_in)
		state_q != ST_IDLE && $past(state_q) != ST_IDLE |-> $stable(dor_q) && $stable(ior_q))
		else $error("select lines changed inside service cycle");
	status_hold_a: assert property (@(posedge clock_in) disable iff (!resetn_in)
		rs_q && doe_q && !ack_s |=> $stable(dout_q) && doe_q)
		else $error("status byte changed before acknowledge");
	chfin_owed_a: assert property (@(posedge clock_in) disable iff (!resetn_in)
		done && to_q && kind_q == svc_pkg::KIND_DIN && term_q[svc_pkg::TO_CNT_DONE]
		|=> auto_q ##1 (state_q != ST_IDLE || !order_output_cycle_q || kind_q == svc_pkg::KIND_OIN))
		else $error("count done did not raise an order input");
	status_bits_a: assert property (@(posedge clock_in) disable iff (!resetn_in)
		start && start_kind == svc_pkg::KIND_OIN |=> dout_q[svc_pkg::SB_TE] ==
		$past(flt_q[svc_pkg::FLT_TE]) && dout_q[svc_pkg::SB_CHF]
		&& dout_q[svc_pkg::SB_WL] == $past(flt_q[svc_pkg::FLT_WL])
		&& dout_q[svc_pkg::SB_ABN] == $past(flt_q[svc_pkg::FLT_ABN])
		&& abn_q == dout_q[svc_pkg::SB_ABN])
		else $error("status byte bits wrong");
endmodule

// >>> verif/iop_model.sv
// Behavioural I/O processor that answers the controller's service cycles
module iop_model (
	input  wire logic              clock_in,
	input  wire logic              resetn_in,
	input  wire svc_pkg::pin_out_t dc_in,
	input  wire logic [7:0]        out_byte_in,
	input  wire logic [7:0]        order_byte_in,
	input  wire logic [2:0]        cut_in,
	input  wire logic              with_order_in,
	input  wire logic [1:0]        delay_in,
	output svc_pkg::pin_in_t       pins_out,
	output logic [1:0]             kind_out,
	output logic [7:0]             got_out,
	output logic [7:0]             nbytes_out,
	output logic [7:0]             ncycles_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic       ack_q = 1'b0;   // Strobe acknowledge
	logic       es_q = 1'b0;    // Service-end flag
	logic       ed_q = 1'b0;    // Our pull on the last-data line
	logic       ord_q = 1'b0;   // Next subcycle carries the terminal order
	logic [7:0] dat_q = 8'hA5;  // Our data lines
	logic [1:0] k = 2'h0;       // Cycle kind latched on the first strobe
	logic       ending;         // Data part ends this subcycle
	logic       fin;            // Service cycle completes this subcycle
	logic       ed_w;           // Wire level of last-data
	int         n = 0;          // Data bytes in this cycle
	// Either party may pull last-data high
	assign ed_w = ed_q | (dc_in.last_data_oe & dc_in.last_data);
	assign pins_out.ack = ack_q;
	assign pins_out.service_end = es_q;
	assign pins_out.last_data = ed_w;
	// Released lines show the inverse of the last value
	assign pins_out.data = dc_in.data_oe ? dc_in.data : dat_q;
	assign kind_out = k;
	// One pass per request strobe
	always begin
		@(posedge clock_in);
		if (!resetn_in) begin
			ord_q <= 1'b0;
			ncycles_out <= 8'h00;
			n = 0;
		end else if (dc_in.strobe === 1'b1) begin
			repeat (delay_in) @(posedge clock_in);
			if (ord_q) begin
				// Order closes a cycle that already moved data
				dat_q <= (k == svc_pkg::KIND_OIN) ? 8'h00 : order_byte_in;
				fin = 1'b1;
			end else begin
				if (n == 0) k = {dc_in.order_sel, dc_in.dir_sel};
				n++;
				if (k[0]) dat_q <= out_byte_in;
				else got_out <= pins_out.data;
				ending = (n == cut_in) || (n == 4) || ed_w;
				fin = ending && !with_order_in;
				ord_q <= ending && with_order_in;
				ed_q <= (n == cut_in) || (n == 4);
			end
			es_q <= fin;
			ack_q <= 1'b1;
			while (dc_in.strobe === 1'b1) @(posedge clock_in);
			ack_q <= 1'b0;
			es_q <= 1'b0;
			ed_q <= 1'b0;
			dat_q <= ~dat_q;
			if (fin) begin
				ord_q <= 1'b0;
				nbytes_out <= 8'(n);
				ncycles_out <= ncycles_out + 8'h01;
				n = 0;
			end
		end
	end
endmodule

// >>> verif/tb_io_service_cycle_order_input.sv
// Bench driving the service-cycle controller against a processor model
module tb_io_service_cycle_order_input;
	timeunit 1ns;
	timeprecision 1ns;
	logic              clock_in = 1'b0;
	logic              resetn_in = 1'b0;
	logic [3:0]        adr = 4'h0;
	logic              rd = 1'b0;
	logic              wr = 1'b0;
	logic [31:0]       wdat = 32'h0;
	logic [31:0]       rdat;
	logic [31:0]       q;
	logic              wait_rq;
	svc_pkg::pin_in_t  pin_i;
	svc_pkg::pin_out_t pin_o;
	logic [7:0]        ob = 8'h00;
	logic [7:0]        ord = 8'h00;
	logic [2:0]        cut = 3'h0;
	logic              wo = 1'b0;
	logic [1:0]        dly = 2'h0;
	logic [1:0]        kind;
	logic [7:0]        got, nb, ncyc, b, b2;
	logic [2:0]        f;
	int                mismatches = 0;
	int                n_compared = 0;
	// Bus clock
	always #25 clock_in = ~clock_in;
	svc_ctrl DUT (.clock_in(clock_in), .resetn_in(resetn_in), .avs_address_in(adr),
		.avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdat),
		.avs_readdata_out(rdat), .avs_waitrequest_out(wait_rq), .pins_in(pin_i),
		.pins_out(pin_o));
	iop_model MODEL (.clock_in(clock_in), .resetn_in(resetn_in), .dc_in(pin_o),
		.out_byte_in(ob), .order_byte_in(ord), .cut_in(cut), .with_order_in(wo),
		.delay_in(dly), .pins_out(pin_i), .kind_out(kind), .got_out(got),
		.nbytes_out(nb), .ncycles_out(ncyc));
	// Prints counts and verdict, then ends the run
	task automatic give_verdict();
		$display("Compared %0d, mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// One Avalon transfer, held until waitrequest is sampled low
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		int t;
		t = 0;
		@(posedge clock_in);
		adr <= a;
		wr <= w;
		rd <= !w;
		wdat <= d;
		do begin
			@(posedge clock_in);
			t++;
		end while (wait_rq !== 1'b0 && t < 50);
		q = rdat;
		wr <= 1'b0;
		rd <= 1'b0;
		if (t >= 50) begin
			mismatches++;
			give_verdict();
		end
	endtask
	// Waits until the model has counted k complete service cycles
	task automatic wait_cyc(input logic [7:0] k);
		int t;
		for (t = 0; t < 3000 && ncyc !== k; t++) @(posedge clock_in);
		// Controller sees the released acknowledge through its synchroniser later
		repeat (3) @(posedge clock_in);
		if (ncyc !== k) begin
			mismatches++;
			give_verdict();
		end
	endtask
	// Sets the model's answers, then starts a cycle
	task automatic run(input logic [31:0] c, input logic [7:0] o, input logic [2:0] k,
		input logic w, input logic [7:0] t);
		ob <= o;
		cut <= k;
		wo <= w;
		ord <= t;
		dly <= 2'($urandom_range(3, 0));
		bus(1'b1, svc_pkg::OFS_CTRL, c);
	endtask
	initial begin
		void'($urandom(50));
		repeat (8) @(posedge clock_in);
		resetn_in <= 1'b1;
		bus(1'b0, svc_pkg::OFS_STAT, 32'h0);
		check("stat reset", q, 32'h0);
		bus(1'b0, 4'h2, 32'h0);
		check("unmapped", q, 32'h0);
		// Order input with nothing owed is refused
		run(32'h22, 8'h00, 3'h1, 1'b1, 8'h00);
		repeat (40) @(posedge clock_in);
		check("refused", ncyc, 8'h00);
		// Stop order brings a channel-finish order input
		run(32'h23, svc_pkg::ORDER_STOP, 3'h1, 1'b1, 8'h00);
		wait_cyc(8'h02);
		check("auto kind", kind, svc_pkg::KIND_OIN);
		check("stop status", got, 8'h08);
		// Plain order leaves an order input owed
		run(32'h23, 8'h01, 3'h1, 1'b1, 8'h00);
		wait_cyc(8'h03);
		bus(1'b0, svc_pkg::OFS_STAT, 32'h0);
		check("owed", q, 32'h0000_0106);
		// Four sent bytes, count done, faults reported
		b = 8'($urandom);
		f = 3'($urandom);
		bus(1'b1, svc_pkg::OFS_TX, {24'h0, b});
		bus(1'b1, svc_pkg::OFS_FLT, {29'h0, f});
		bus(1'b0, svc_pkg::OFS_TX, 32'h0);
		check("tx readback", q, {24'h0, b});
		bus(1'b0, svc_pkg::OFS_FLT, 32'h0);
		check("flt readback", q, {29'h0, f});
		run(32'h2C, 8'h00, 3'h0, 1'b1, 8'h02);
		wait_cyc(8'h04);
		check("sent count", nb, 8'h04);
		check("sent byte", got, b);
		wait_cyc(8'h05);
		check("fault status", got, {3'h0, f[2], 2'h2, f[1:0]});
		bus(1'b0, svc_pkg::OFS_STAT, 32'h0);
		check("owed cleared", q[3:0], 4'h2);
		// Processor cuts a four-byte receive after two
		b2 = 8'($urandom);
		run(32'h2D, b2, 3'h2, 1'b1, 8'h00);
		wait_cyc(8'h06);
		check("cut count", nb, 8'h02);
		bus(1'b0, svc_pkg::OFS_STAT, 32'h0);
		check("cut stat", q, {16'h0, b2, 8'h02});
		// One byte closed by service-end, no order
		run(32'h20, 8'h00, 3'h1, 1'b0, 8'h00);
		wait_cyc(8'h07);
		check("single count", nb, 8'h01);
		check("single byte", got, b);
		give_verdict();
	end
endmodule
